// [design/tpo_pkg.sv]
package tpo_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [31:0] ADDR_BUFFER_LOW  = 32'hFFFFF6E0;
    localparam logic [31:0] ADDR_BUFFER_HIGH = 32'hFFFFF6E2;
    localparam logic [31:0] ADDR_MODE_MASK   = 32'hFFFFF6E4;
    localparam logic [31:0] ADDR_CONTROL     = 32'hFFFFF6E5;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_EDGE_BIT = 6;
    localparam int CTRL_CFG_BIT  = 5;
    localparam int CTRL_TRIG_BIT = 4;

    localparam logic [7:0] CTRL_RW_MASK = 8'hF0;
    localparam logic [7:0] MODE_RW_MASK = 8'h3F;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int OUT_W  = 6;
    localparam int LOW_W  = 4;
    localparam int HIGH_W = 2;

    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] MODE_RESET   = 8'h00;
    localparam logic [3:0] BUFFER_RESET = 4'h0;

endpackage : tpo_pkg

// [design/tpo_trigger_sel.sv]
`timescale 1ns/1ps

module tpo_trigger_sel (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic capture_timer_event,
    input  wire logic interval_timer_a_event,
    input  wire logic interval_timer_b_event,
    input  wire logic trigger_edge_select,
    input  wire logic channel_config_select,
    input  wire logic trigger_source_select,
    output logic      trig_high,
    output logic      trig_low
);

    typedef struct packed {
        logic cap_prev;
    } tpo_trig_state_s;

    tpo_trig_state_s st_ff;
    tpo_trig_state_s nxt_st;
    logic            cap_edge;

    // ------------------------------------------------------------
    // Edge detection of the capture timer event
    // ------------------------------------------------------------
    // The capture event is a wide pulse, so only its selected edge counts.
    always_comb begin
        nxt_st          = st_ff;
        nxt_st.cap_prev = capture_timer_event;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cap_edge = trigger_edge_select ? (capture_timer_event & ~st_ff.cap_prev)
                                          : (~capture_timer_event & st_ff.cap_prev);

    // ------------------------------------------------------------
    // Trigger routing
    // ------------------------------------------------------------
    always_comb begin
        if (channel_config_select) begin
            trig_high = trigger_source_select ? cap_edge : interval_timer_a_event;
            trig_low  = trig_high;
        end else begin
            trig_high = trigger_source_select ? interval_timer_a_event : interval_timer_b_event;
            trig_low  = trigger_source_select ? cap_edge : interval_timer_a_event;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_cap_rise_edge: assert property (trigger_edge_select && capture_timer_event && !st_ff.cap_prev
        && channel_config_select && trigger_source_select |-> trig_high && trig_low)
        else $error("rising capture edge did not trigger");
    a_cap_fall_only: assert property (!trigger_edge_select && capture_timer_event
        && channel_config_select && trigger_source_select |-> !trig_high)
        else $error("capture high level triggered on falling edge select");
    a_split_route: assert property (!channel_config_select && !trigger_source_select
        |-> trig_high == interval_timer_b_event && trig_low == interval_timer_a_event)
        else $error("split trigger routing wrong");

endmodule : tpo_trigger_sel

// [design/tpo_port.sv]
`timescale 1ns/1ps

module tpo_port (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [31:0] bus_addr,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    input  wire logic [7:0]  bus_wmask,
    input  wire logic [7:0]  bus_wdata,
    output logic      [7:0]  bus_rdata,
    input  wire logic        capture_timer_event,
    input  wire logic        interval_timer_a_event,
    input  wire logic        interval_timer_b_event,
    output logic      [5:0]  timed_output_signals
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [3:0] buf_hi;
        logic [3:0] buf_lo;
        logic [1:0] latch_hi;
        logic [3:0] latch_lo;
        logic [7:0] rdata;
        logic [5:0] out;
    } tpo_state_s;

    tpo_state_s st_ff;
    tpo_state_s nxt_st;

    logic       hit_ctrl;
    logic       hit_mode;
    logic       hit_lo;
    logic       hit_hi;
    logic       enabled;
    logic       combined;
    logic       trig_high;
    logic       trig_low;
    logic       wr_lo;
    logic       wr_hi;
    logic [7:0] buf_byte;
    logic [7:0] buf_merged;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    assign hit_ctrl = bus_addr == tpo_pkg::ADDR_CONTROL;
    assign hit_mode = bus_addr == tpo_pkg::ADDR_MODE_MASK;
    assign hit_lo   = bus_addr == tpo_pkg::ADDR_BUFFER_LOW;
    assign hit_hi   = bus_addr == tpo_pkg::ADDR_BUFFER_HIGH;
    assign enabled  = st_ff.ctrl[tpo_pkg::CTRL_EN_BIT];
    assign combined = st_ff.ctrl[tpo_pkg::CTRL_CFG_BIT];
    assign buf_byte = {st_ff.buf_hi, st_ff.buf_lo};

    // Combined mode lets either address reach both nibbles.
    assign wr_lo = bus_wr && (hit_lo || (combined && hit_hi));
    assign wr_hi = bus_wr && (hit_hi || (combined && hit_lo));

    // Merges written bits under the lane mask, so one-hot masks give bit access.
    function automatic logic [7:0] tpo_merge(input logic [7:0] old_v,
                                             input logic [7:0] new_v,
                                             input logic [7:0] mask);
        tpo_merge = (old_v & ~mask) | (new_v & mask);
    endfunction : tpo_merge

    assign buf_merged = tpo_merge(buf_byte, bus_wdata, bus_wmask);

    // ------------------------------------------------------------
    // Trigger selection
    // ------------------------------------------------------------
    tpo_trigger_sel u_trigger_sel (
        .clock                  (clock),
        .sys_rst                (sys_rst),
        .capture_timer_event    (capture_timer_event),
        .interval_timer_a_event (interval_timer_a_event),
        .interval_timer_b_event (interval_timer_b_event),
        .trigger_edge_select    (st_ff.ctrl[tpo_pkg::CTRL_EDGE_BIT]),
        .channel_config_select  (st_ff.ctrl[tpo_pkg::CTRL_CFG_BIT]),
        .trigger_source_select  (st_ff.ctrl[tpo_pkg::CTRL_TRIG_BIT]),
        .trig_high              (trig_high),
        .trig_low               (trig_low)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        if (bus_wr && hit_ctrl) begin
            nxt_st.ctrl = tpo_merge(st_ff.ctrl, bus_wdata, bus_wmask) & tpo_pkg::CTRL_RW_MASK;
        end
        if (bus_wr && hit_mode) begin
            nxt_st.mode = tpo_merge(st_ff.mode, bus_wdata, bus_wmask) & tpo_pkg::MODE_RW_MASK;
        end
        if (wr_hi) begin
            nxt_st.buf_hi = buf_merged[7:4];
        end
        if (wr_lo) begin
            nxt_st.buf_lo = buf_merged[3:0];
        end

        // Disabled writes go straight through; enabled writes wait for a trigger.
        if (!enabled) begin
            if (wr_hi) begin
                nxt_st.latch_hi = buf_merged[5:4];
            end
            if (wr_lo) begin
                nxt_st.latch_lo = buf_merged[3:0];
            end
        end else begin
            if (trig_high) begin
                nxt_st.latch_hi = st_ff.buf_hi[1:0];
            end
            if (trig_low) begin
                nxt_st.latch_lo = st_ff.buf_lo;
            end
        end

        if (nxt_st.ctrl[tpo_pkg::CTRL_EN_BIT]) begin
            nxt_st.out = {nxt_st.latch_hi, nxt_st.latch_lo} & nxt_st.mode[5:0];
        end else begin
            nxt_st.out = 6'h00;
        end

        // Read data is a one-cycle answer; unmapped addresses read zero.
        nxt_st.rdata = 8'h00;
        if (bus_rd) begin
            if (hit_ctrl) begin
                nxt_st.rdata = st_ff.ctrl;
            end else if (hit_mode) begin
                nxt_st.rdata = st_ff.mode;
            end else if (hit_lo || hit_hi) begin
                nxt_st.rdata = buf_byte;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff        <= '0;
            st_ff.ctrl   <= tpo_pkg::CTRL_RESET;
            st_ff.mode   <= tpo_pkg::MODE_RESET;
            st_ff.buf_hi <= tpo_pkg::BUFFER_RESET;
            st_ff.buf_lo <= tpo_pkg::BUFFER_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus_rdata            = st_ff.rdata;
    assign timed_output_signals = st_ff.out;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_low_trigger_enabled;
        enabled && trig_low && !bus_wr;
    endsequence

    sequence s_high_trigger_enabled;
        enabled && trig_high && !bus_wr;
    endsequence

    sequence s_full_low_write_split;
        bus_wr && hit_lo && !combined && bus_wmask == 8'hFF;
    endsequence

    sequence s_full_write_disabled;
        s_full_low_write_split ##0 !enabled;
    endsequence

    a_disabled_out_zero: assert property (!enabled |-> timed_output_signals == 6'h00)
        else $error("outputs not zero while disabled");
    a_enabled_out_mask: assert property (enabled
        |-> timed_output_signals == ({st_ff.latch_hi, st_ff.latch_lo} & st_ff.mode[5:0]))
        else $error("enabled outputs do not follow latch and mask");
    a_low_trig_copy: assert property (s_low_trigger_enabled |=> st_ff.latch_lo == $past(st_ff.buf_lo))
        else $error("low latch missed trigger copy");
    a_high_trig_copy: assert property (s_high_trigger_enabled
        |=> st_ff.latch_hi == $past(st_ff.buf_hi[1:0]))
        else $error("high latch missed trigger copy");
    a_split_keeps_high: assert property (s_full_low_write_split |=> st_ff.buf_hi == $past(st_ff.buf_hi))
        else $error("split write to low touched high buffer");
    a_combined_both: assert property (bus_wr && hit_hi && combined && bus_wmask == 8'hFF
        |=> st_ff.buf_lo == $past(bus_wdata[3:0]) && st_ff.buf_hi == $past(bus_wdata[7:4]))
        else $error("combined write did not load both buffers");
    a_direct_latch: assert property (s_full_write_disabled |=> st_ff.latch_lo == $past(bus_wdata[3:0]))
        else $error("disabled write did not reach latch");
    a_enabled_no_pass: assert property (s_full_low_write_split ##0 enabled && !trig_low
        |=> st_ff.latch_lo == $past(st_ff.latch_lo))
        else $error("enabled write reached latch without trigger");
    a_buffer_read: assert property (bus_rd && (hit_lo || hit_hi)
        |=> bus_rdata == {$past(st_ff.buf_hi), $past(st_ff.buf_lo)})
        else $error("buffer read value wrong");
    a_ctrl_low_zero: assert property (bus_rd && hit_ctrl |=> bus_rdata[3:0] == 4'h0
        && bus_rdata[7] == $past(enabled))
        else $error("control read value wrong");
    a_mode_read: assert property (bus_rd && hit_mode |=> bus_rdata == {2'h0, $past(st_ff.mode[5:0])})
        else $error("mode mask read value wrong");
    a_bit_write: assert property (bus_wr && hit_mode && bus_wmask == 8'h01
        |=> st_ff.mode[7:1] == $past(st_ff.mode[7:1]) && st_ff.mode[0] == $past(bus_wdata[0]))
        else $error("single-bit write disturbed other bits");

endmodule : tpo_port

// [verification/tpo_motor_model.sv]
`timescale 1ns/1ps

// ------------------------------------------------------------
// Stepping-motor driver
// ------------------------------------------------------------
// The driver only takes in phases and drives nothing back to the port.
// It counts every change of the phase pattern.
module tpo_motor_model (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [5:0] phase_in,
    output logic      [7:0] step_count
);
    logic [5:0] last_phase;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            last_phase <= 6'h00;
            step_count <= 8'h00;
        end else begin
            last_phase <= phase_in;
            if (phase_in != last_phase) begin
                step_count <= step_count + 8'h01;
            end
        end
    end
endmodule : tpo_motor_model

// [verification/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
    localparam logic [31:0] LO = tpo_pkg::ADDR_BUFFER_LOW;
    localparam logic [31:0] HI = tpo_pkg::ADDR_BUFFER_HIGH;
    localparam logic [31:0] MM = tpo_pkg::ADDR_MODE_MASK;
    localparam logic [31:0] CT = tpo_pkg::ADDR_CONTROL;

    typedef struct packed {
        logic       cfg;
        logic       trg;
        logic       edg;
        logic [1:0] src;
        logic [5:0] exp;
    } tpo_row_s;

    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [31:0] bus_addr = 32'h00000000;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [7:0]  bus_wmask = 8'hFF;
    logic [7:0]  bus_wdata = 8'h00;
    logic [7:0]  bus_rdata;
    logic        capture_timer_event = 1'b0;
    logic        interval_timer_a_event = 1'b0;
    logic        interval_timer_b_event = 1'b0;
    logic [5:0]  timed_output_signals;
    logic [7:0]  step_count;
    int          bad_count = 0;
    int          check_count = 0;

    // Source 0 is interval timer A, 1 is interval timer B, 2 is the capture timer.
    tpo_row_s rows [9] = '{
        '{1'b0, 1'b0, 1'b0, 2'h0, 6'h15}, '{1'b0, 1'b0, 1'b0, 2'h1, 6'h2A},
        '{1'b0, 1'b1, 1'b0, 2'h0, 6'h2A}, '{1'b0, 1'b1, 1'b1, 2'h2, 6'h15},
        '{1'b0, 1'b1, 1'b0, 2'h2, 6'h15}, '{1'b1, 1'b0, 1'b0, 2'h0, 6'h25},
        '{1'b1, 1'b0, 1'b0, 2'h1, 6'h1A}, '{1'b1, 1'b1, 1'b1, 2'h2, 6'h25},
        '{1'b1, 1'b1, 1'b0, 2'h2, 6'h25}};

    tpo_port dut (
        .clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_wmask(bus_wmask), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .capture_timer_event(capture_timer_event), .interval_timer_a_event(interval_timer_a_event),
        .interval_timer_b_event(interval_timer_b_event), .timed_output_signals(timed_output_signals));

    tpo_motor_model motor (
        .clock(clock), .sys_rst(sys_rst), .phase_in(timed_output_signals), .step_count(step_count));

    initial begin
        forever #10 clock = ~clock;
    end

    task automatic stop_test;
        $display("Counts: %0d checks, %0d mismatches", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge clock);
        #1;
        bus_addr = a;
        bus_wdata = d;
        bus_wmask = m;
        bus_wr = 1'b1;
        @(posedge clock);
        #1;
        bus_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [7:0] e, input string name);
        @(posedge clock);
        #1;
        bus_addr = a;
        bus_rd = 1'b1;
        @(posedge clock);
        #1;
        bus_rd = 1'b0;
        chk(name, bus_rdata, e);
    endtask : rd

    task automatic chk_out(input string name, input logic [5:0] e);
        repeat (2) @(posedge clock);
        #1;
        chk(name, {2'h0, timed_output_signals}, {2'h0, e});
    endtask : chk_out

    // The capture event stays high for three clocks, the interval events for one.
    task automatic fire(input logic [1:0] src, input logic edg, input logic [5:0] e);
        @(posedge clock);
        #1;
        interval_timer_a_event = (src == 2'h0);
        interval_timer_b_event = (src == 2'h1);
        capture_timer_event = (src == 2'h2);
        @(posedge clock);
        #1;
        interval_timer_a_event = 1'b0;
        interval_timer_b_event = 1'b0;
        chk_out("after rise", (capture_timer_event && !edg) ? 6'h1A : e);
        capture_timer_event = 1'b0;
        chk_out("after fall", e);
    endtask : fire

    initial begin
        #200000;
        bad_count++;
        stop_test();
    end

    initial begin
        repeat (3) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            wr(CT, 8'h00, 8'hFF);
            wr(CT, {1'b0, rows[i].edg, rows[i].cfg, rows[i].trg, 4'h0}, 8'hFF);
            wr(MM, 8'h3F, 8'hFF);
            wr(HI, 8'h1A, 8'hFF);
            wr(LO, 8'h1A, 8'hFF);
            wr(CT, {1'b1, rows[i].edg, rows[i].cfg, rows[i].trg, 4'h0}, 8'hFF);
            chk_out("enable", 6'h1A);
            wr(HI, 8'h2C, 8'hFF);
            wr(LO, rows[i].cfg ? 8'h25 : 8'hE5, 8'hFF);
            chk_out("held", 6'h1A);
            rd(HI, 8'h25, "buffers");
            fire(rows[i].src, rows[i].edg, rows[i].exp);
            $display("Test row %0d done", i);
        end
        sys_rst = 1'b1;
        repeat (3) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        chk("reset out", {2'h0, timed_output_signals}, 8'h00);
        rd(CT, 8'h00, "reset ctrl");
        rd(MM, 8'h00, "reset mode");
        rd(LO, 8'h00, "reset buf");
        $display("Test reset done");
        wr(CT, 8'h0F, 8'hFF);
        rd(CT, 8'h00, "ctrl low");
        wr(MM, 8'hFF, 8'hFF);
        rd(MM, 8'h3F, "mode top");
        $display("Test reserved done");
        wr(HI, 8'h3F, 8'hFF);
        wr(LO, 8'h0F, 8'hFF);
        wr(MM, 8'h25, 8'hFF);
        wr(CT, 8'h80, 8'hFF);
        chk_out("mask", 6'h25);
        wr(CT, 8'h00, 8'hFF);
        chk_out("disabled", 6'h00);
        $display("Test mask done");
        wr(LO, 8'h00, 8'h01);
        wr(HI, 8'h00, 8'h10);
        rd(LO, 8'h2E, "bit write");
        $display("Test bits done");
        wr(32'hFFFFF6E1, 8'hFF, 8'hFF);
        rd(32'hFFFFF6E1, 8'h00, "unmapped");
        rd(HI, 8'h2E, "unmapped wr");
        @(posedge clock);
        #1;
        chk("rdata idle", bus_rdata, 8'h00);
        chk("motor steps", {7'h00, step_count == 8'h00}, 8'h00);
        $display("Test unmapped done");
        stop_test();
    end
endmodule : tb_top
